// File: src/dhs_avg_filter.sv
// Holdover averaging filter with one, eight and 64 second history
`timescale 1ns/100ps
module dhs_avg_filter
  import dhs_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic               clk_en,
  input  wire logic               track,
  input  wire logic               sec_tick,
  input  wire logic [1:0]         filt_sel,
  input  wire logic signed [39:0] freq_in,
  output logic signed [39:0]      avg_now,
  output logic signed [39:0]      avg_1s,
  output logic signed [39:0]      avg_8s,
  output logic signed [39:0]      avg_64s
);
  logic        [5:0]  sec_cnt;
  logic        [5:0]  next_sec_cnt;
  logic signed [39:0] next_avg;
  logic signed [39:0] next_1s;
  logic signed [39:0] next_8s;
  logic signed [39:0] next_64s;
  logic signed [40:0] diff;

  always_comb begin
    diff = 41'(freq_in) - 41'(avg_now);
    next_avg = avg_now;
    next_sec_cnt = sec_cnt;
    next_1s = avg_1s;
    next_8s = avg_8s;
    next_64s = avg_64s;
    // Only locked operation feeds the average
    if (track) begin
      case (filt_sel)
        2'h0:    next_avg = avg_now + 40'(diff >>> FILT_SHIFT0);
        2'h1:    next_avg = avg_now + 40'(diff >>> FILT_SHIFT1);
        2'h2:    next_avg = avg_now + 40'(diff >>> FILT_SHIFT2);
        default: next_avg = avg_now + 40'(diff >>> FILT_SHIFT3);
      endcase
    end
    // Snapshots age between zero and one period of their step
    if (sec_tick) begin
      next_sec_cnt = sec_cnt + 6'h01;
      next_1s = avg_now;
      if (sec_cnt[2:0] == 3'(HIST8_SECONDS - 1)) begin
        next_8s = avg_now;
      end
      if (sec_cnt == 6'(HIST64_SECONDS - 1)) begin
        next_64s = avg_now;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      avg_now <= 40'sh0000000000;
      avg_1s  <= 40'sh0000000000;
      avg_8s  <= 40'sh0000000000;
      avg_64s <= 40'sh0000000000;
      sec_cnt <= 6'h00;
    end else if (clk_en) begin
      avg_now <= next_avg;
      avg_1s  <= next_1s;
      avg_8s  <= next_8s;
      avg_64s <= next_64s;
      sec_cnt <= next_sec_cnt;
    end
  end
endmodule

// File: src/dhs_ctrl.sv
// Holdover, hitless switching and phase slope control for one loop
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module dhs_ctrl
  import dhs_pkg::*;
#(
  parameter int TICKS_PER_SEC = TICKS_SEC_DFLT
)(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic               clk_en,
  input  wire logic [5:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic [2:0]         op_mode,
  input  wire logic [2:0]         sel_ref,
  input  wire logic signed [39:0] loop_freq,
  input  wire logic signed [31:0] phase_meas,
  output logic                    holdover_active,
  output logic                    phase_lock_en,
  output logic signed [39:0]      holdover_freq,
  output logic signed [31:0]      phase_comp,
  output logic                    hitless_event,
  output logic [23:0]             slope_limit,
  output logic                    mode_change_irq
);
  typedef enum logic {HO_TRACK, HO_HOLD} dhs_ho_type;

  logic        [6:0]  method;
  logic        [39:0] man_offset;
  logic        [1:0]  switch_cfg;
  logic        [2:0]  slope_sel;
  logic        [23:0] prog_slope;
  logic               mode_flag;
  logic               flag_mask;
  logic               resp_q;
  logic        [31:0] next_readdata;
  logic        [6:0]  next_method;
  logic        [39:0] next_man_offset;
  logic        [1:0]  next_switch_cfg;
  logic        [2:0]  next_slope_sel;
  logic        [23:0] next_prog_slope;
  logic               next_mode_flag;
  logic               next_flag_mask;
  logic               req;
  logic               wr_go;
  logic        [31:0] wmerged;
  logic               mode_changed;
  dhs_ho_type         ho_state;
  dhs_ho_type         next_ho_state;
  logic signed [39:0] next_holdover_freq;
  logic signed [39:0] sel_freq;
  logic signed [39:0] acq_freq;
  logic signed [39:0] rd_offset;
  logic signed [39:0] avg_now;
  logic signed [39:0] avg_1s;
  logic signed [39:0] avg_8s;
  logic signed [39:0] avg_64s;
  logic        [26:0] tick_cnt;
  logic        [26:0] next_tick_cnt;
  logic               sec_tick;
  logic        [2:0]  prev_sel;
  logic        [2:0]  prev_mode;
  logic               hs_trig;
  logic               next_hitless_event;
  logic signed [31:0] next_phase_comp;
  logic        [27:0] slew_acc;
  logic        [27:0] next_slew_acc;
  logic        [27:0] acc_sum;

  // Byte-lane merge of a write into the old register contents
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic free_or_hold(input logic [2:0] m);
    return (m == MODE_FREE_RUN) || (m == MODE_HOLDOVER);
  endfunction

  // Bus slave: one wait cycle, answer on the second cycle
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !resp_q;
  assign wr_go = clk_en && avs_write && resp_q;
  assign mode_changed = op_mode != prev_mode;

  always_comb begin
    wmerged = 32'h00000000;
    case (avs_address)
      OFS_METHOD:     wmerged = be_merge({25'h0, method}, avs_writedata,
                                         avs_byteenable);
      OFS_MAN_LO:     wmerged = be_merge(man_offset[31:0], avs_writedata,
                                         avs_byteenable);
      OFS_MAN_HI:     wmerged = be_merge({24'h0, man_offset[39:32]},
                                         avs_writedata, avs_byteenable);
      OFS_SWITCH:     wmerged = be_merge({30'h0, switch_cfg}, avs_writedata,
                                         avs_byteenable);
      OFS_SLOPE_SEL:  wmerged = be_merge({29'h0, slope_sel}, avs_writedata,
                                         avs_byteenable);
      OFS_PROG_SLOPE: wmerged = be_merge({8'h0, prog_slope}, avs_writedata,
                                         avs_byteenable);
      OFS_MASK:       wmerged = be_merge({31'h0, flag_mask}, avs_writedata,
                                         avs_byteenable);
      default:        wmerged = avs_writedata;
    endcase
  end

  always_comb begin
    next_method = method;
    next_man_offset = man_offset;
    next_switch_cfg = switch_cfg;
    next_slope_sel = slope_sel;
    next_prog_slope = prog_slope;
    next_flag_mask = flag_mask;
    next_mode_flag = mode_flag;
    if (wr_go) begin
      case (avs_address)
        OFS_METHOD:     next_method = wmerged[6:0];
        OFS_MAN_LO:     next_man_offset[31:0] = wmerged;
        OFS_MAN_HI:     next_man_offset[39:32] = wmerged[7:0];
        OFS_SWITCH:     next_switch_cfg = wmerged[1:0];
        OFS_SLOPE_SEL:  next_slope_sel = wmerged[2:0];
        OFS_PROG_SLOPE: next_prog_slope = wmerged[23:0];
        OFS_MASK:       next_flag_mask = wmerged[0];
        OFS_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[BIT_MODE_FLAG]) begin
            next_mode_flag = 1'b0;
          end
        end
        default:        next_method = method;
      endcase
    end
    // A mode change in the clearing cycle still sets the flag
    if (mode_changed) begin
      next_mode_flag = 1'b1;
    end
    rd_offset = method[BIT_READ_AVG] ? acq_freq : man_offset;
    case (avs_address)
      OFS_METHOD:     next_readdata = {25'h0, method};
      OFS_MAN_LO:     next_readdata = rd_offset[31:0];
      OFS_MAN_HI:     next_readdata = {24'h0, rd_offset[39:32]};
      OFS_SWITCH:     next_readdata = {30'h0, switch_cfg};
      OFS_SLOPE_SEL:  next_readdata = {29'h0, slope_sel};
      OFS_PROG_SLOPE: next_readdata = {8'h0, prog_slope};
      OFS_STATUS:     next_readdata = {30'h0, holdover_active, mode_flag};
      OFS_MASK:       next_readdata = {31'h0, flag_mask};
      OFS_PHASE:      next_readdata = phase_comp;
      default:        next_readdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      method       <= METHOD_RST;
      man_offset   <= 40'h0000000000;
      switch_cfg   <= SWITCH_RST;
      slope_sel    <= SLOPE_SEL_RST;
      prog_slope   <= PROG_SLOPE_RST;
      mode_flag    <= 1'b0;
      flag_mask    <= 1'b0;
      resp_q       <= 1'b0;
      avs_readdata <= 32'h00000000;
      prev_mode    <= MODE_FREE_RUN;
    end else if (clk_en) begin
      method       <= next_method;
      man_offset   <= next_man_offset;
      switch_cfg   <= next_switch_cfg;
      slope_sel    <= next_slope_sel;
      prog_slope   <= next_prog_slope;
      mode_flag    <= next_mode_flag;
      flag_mask    <= next_flag_mask;
      resp_q       <= req && !resp_q;
      avs_readdata <= (avs_read && !resp_q) ? next_readdata : avs_readdata;
      prev_mode    <= op_mode;
    end
  end

  assign mode_change_irq = mode_flag && flag_mask;

  // Second tick for the history snapshots
  always_comb begin
    sec_tick = tick_cnt == 27'(TICKS_PER_SEC - 1);
    next_tick_cnt = sec_tick ? 27'h0000000 : tick_cnt + 27'h0000001;
  end

  dhs_avg_filter i_dhs_avg_filter (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .track    (op_mode == MODE_LOCKED),
    .sec_tick (sec_tick),
    .filt_sel (method[POS_FILT +: 2]),
    .freq_in  (loop_freq),
    .avg_now  (avg_now),
    .avg_1s   (avg_1s),
    .avg_8s   (avg_8s),
    .avg_64s  (avg_64s)
  );

  // Holdover source selection and entry latch
  always_comb begin
    if (method[BIT_MANUAL]) begin
      sel_freq = man_offset;
    end else if (!method[BIT_AUTO_AVG]) begin
      sel_freq = avg_now;
    end else begin
      case (method[POS_HIST +: 2])
        HIST_NOW: sel_freq = avg_now;
        HIST_1S:  sel_freq = avg_1s;
        HIST_8S:  sel_freq = avg_8s;
        default:  sel_freq = avg_64s;
      endcase
    end
    acq_freq = holdover_active ? holdover_freq : sel_freq;
    next_ho_state = ho_state;
    next_holdover_freq = holdover_freq;
    case (ho_state)
      HO_TRACK: begin
        if (op_mode == MODE_HOLDOVER) begin
          next_ho_state = HO_HOLD;
          next_holdover_freq = sel_freq;
        end
      end
      HO_HOLD: begin
        if (op_mode != MODE_HOLDOVER) begin
          next_ho_state = HO_TRACK;
        end
      end
      default: next_ho_state = HO_TRACK;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ho_state      <= HO_TRACK;
      holdover_freq <= 40'sh0000000000;
      tick_cnt      <= 27'h0000000;
    end else if (clk_en) begin
      ho_state      <= next_ho_state;
      holdover_freq <= next_holdover_freq;
      tick_cnt      <= next_tick_cnt;
    end
  end

  assign holdover_active = ho_state == HO_HOLD;
  // Stored value drives the loop; no phase tracking meanwhile
  assign phase_lock_en = !holdover_active &&
                         !free_or_hold(op_mode);

  // Slope limit decode
  always_comb begin
    case (slope_sel)
      3'h0:    slope_limit = SLOPE_61US;
      3'h1:    slope_limit = SLOPE_885NS;
      3'h2:    slope_limit = SLOPE_7U5;
      3'h3:    slope_limit = SLOPE_1M4;
      3'h4:    slope_limit = SLOPE_1NS;
      3'h5:    slope_limit = SLOPE_5NS;
      3'h6:    slope_limit = SLOPE_10NS;
      default: slope_limit = prog_slope;
    endcase
  end

  // Hitless switching and slewing of the phase compensation
  always_comb begin
    hs_trig = switch_cfg[BIT_HIT_EN] && !switch_cfg[BIT_FREEZE] &&
              ((sel_ref != prev_sel) ||
               (free_or_hold(prev_mode) && !free_or_hold(op_mode)));
    next_hitless_event = hs_trig;
    next_phase_comp = phase_comp;
    next_slew_acc = 28'h0000000;
    acc_sum = slew_acc + 28'(slope_limit);
    if (hs_trig) begin
      next_phase_comp = phase_meas;
    end else if (!switch_cfg[BIT_HIT_EN] && !switch_cfg[BIT_FREEZE] &&
                 phase_comp != 32'sh00000000) begin
      // At most one unit per cycle, so the rate never beats the limit
      if (acc_sum >= 28'(TICKS_PER_SEC)) begin
        next_slew_acc = acc_sum - 28'(TICKS_PER_SEC);
        // Surplus over one unit is dropped so a lower limit acts at once
        if (next_slew_acc >= 28'(TICKS_PER_SEC)) begin
          next_slew_acc = 28'(TICKS_PER_SEC - 1);
        end
        next_phase_comp = phase_comp[31] ? phase_comp + 32'sh00000001
                                         : phase_comp - 32'sh00000001;
      end else begin
        next_slew_acc = acc_sum;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_sel      <= 3'h0;
      hitless_event <= 1'b0;
      phase_comp    <= 32'sh00000000;
      slew_acc      <= 28'h0000000;
    end else if (clk_en) begin
      prev_sel      <= sel_ref;
      hitless_event <= next_hitless_event;
      phase_comp    <= next_phase_comp;
      slew_acc      <= next_slew_acc;
    end
  end

  default clocking dhs_cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence bus_wait_s;
    clk_en && req && avs_waitrequest;
  endsequence
  sequence bus_ack_s;
    !avs_waitrequest;
  endsequence

  bus_answer_a: assert property (bus_wait_s |=> bus_ack_s)
    else $error("bus answer not one cycle after request");
  ho_entry_latch_a: assert property ($rose(holdover_active) |->
      holdover_freq == $past(sel_freq))
    else $error("holdover entry did not latch selected value");
  ho_hold_stable_a: assert property (holdover_active &&
      $past(holdover_active) |-> $stable(holdover_freq))
    else $error("holdover value moved during holdover");
  no_lock_ho_a: assert property (holdover_active |-> !phase_lock_en)
    else $error("phase lock enabled in holdover");
  manual_src_a: assert property (method[BIT_MANUAL] |->
      sel_freq == man_offset)
    else $error("manual select did not use manual offset");
  readback_sel_a: assert property (!method[BIT_READ_AVG] |->
      rd_offset == man_offset)
    else $error("readback did not return written offset");
  hs_trigger_a: assert property (clk_en && switch_cfg == 2'h1 &&
      sel_ref != prev_sel |=> hitless_event &&
      phase_comp == $past(phase_meas))
    else $error("reference change did not trigger hitless event");
  hs_freeze_a: assert property (clk_en && switch_cfg[BIT_FREEZE] |=>
      !hitless_event && $stable(phase_comp))
    else $error("hitless freeze did not hold compensation");
  slope_prog_a: assert property (slope_sel == SLOPE_PROG |->
      slope_limit == prog_slope)
    else $error("programmable slope not applied");
  slew_step_a: assert property (clk_en && !switch_cfg[BIT_HIT_EN] |=>
      (phase_comp - $past(phase_comp) <= 32'sh00000001) &&
      ($past(phase_comp) - phase_comp <= 32'sh00000001))
    else $error("phase slewed faster than one unit per cycle");
  flag_set_a: assert property (clk_en && mode_changed |=> mode_flag)
    else $error("mode change did not set flag");
endmodule

// File: src/dhs_pkg.sv
// Constants shared by the holdover, hitless and slope control block
// Notes on behaviour
// - Holdover uses stored frequency, never phase-locks
// - Manual select overrides average, history, filter
// - Manual select uses 40-bit written offset
// - History picks now, 1s, 8s, 64s
// - Filter field picks averaging bandwidth
// - Reset method: current average, 1.5 mHz
// - Readback bit picks acquired or written offset
// - Offset is two's complement, +/-92 ppm
// - Hitless event on reference change or mode exit
// - Event loads measured phase as compensation
// - Freeze ignores events, holds compensation
// - Hitless off: slew to zero, slope bounded
// - Three-bit slope code picks rate limit
// - Reset: programmable slope limit of zero
// - Programmable mode uses 24-bit slope value
// - Mode change sets flag, mask gates interrupt
package dhs_pkg;
  // Register byte offsets
  localparam logic [5:0]  OFS_METHOD      = 6'h00;
  localparam logic [5:0]  OFS_MAN_LO      = 6'h04;
  localparam logic [5:0]  OFS_MAN_HI      = 6'h08;
  localparam logic [5:0]  OFS_SWITCH      = 6'h0C;
  localparam logic [5:0]  OFS_SLOPE_SEL   = 6'h10;
  localparam logic [5:0]  OFS_PROG_SLOPE  = 6'h14;
  localparam logic [5:0]  OFS_STATUS      = 6'h18;
  localparam logic [5:0]  OFS_MASK        = 6'h1C;
  localparam logic [5:0]  OFS_PHASE       = 6'h20;
  // Field positions in holdover_method_config
  localparam int          BIT_MANUAL      = 0;
  localparam int          BIT_AUTO_AVG    = 1;
  localparam int          POS_HIST        = 2;
  localparam int          POS_FILT        = 4;
  localparam int          BIT_READ_AVG    = 6;
  // Field positions in switch_monitor_config and status
  localparam int          BIT_HIT_EN      = 0;
  localparam int          BIT_FREEZE      = 1;
  localparam int          BIT_MODE_FLAG   = 0;
  localparam int          BIT_HO_ACTIVE   = 1;
  // Reset values
  localparam logic [6:0]  METHOD_RST      = 7'h10;
  localparam logic [1:0]  SWITCH_RST      = 2'h0;
  localparam logic [2:0]  SLOPE_SEL_RST   = 3'h7;
  localparam logic [23:0] PROG_SLOPE_RST  = 24'h000000;
  // Operating mode codes from the mode state machine
  localparam logic [2:0]  MODE_FREE_RUN   = 3'h1;
  localparam logic [2:0]  MODE_HOLDOVER   = 3'h2;
  localparam logic [2:0]  MODE_LOCKED     = 3'h4;
  // History codes
  localparam logic [1:0]  HIST_NOW        = 2'h0;
  localparam logic [1:0]  HIST_1S         = 2'h1;
  localparam logic [1:0]  HIST_8S         = 2'h2;
  localparam logic [1:0]  HIST_64S        = 2'h3;
  localparam int          HIST8_SECONDS   = 8;
  localparam int          HIST64_SECONDS  = 64;
  // Averaging shift per filter code: 0.18 mHz, 1.5 mHz, 12 mHz, 0.1 Hz
  localparam int          FILT_SHIFT0     = 23;
  localparam int          FILT_SHIFT1     = 20;
  localparam int          FILT_SHIFT2     = 17;
  localparam int          FILT_SHIFT3     = 14;
  // Slope unit: full 24-bit range equals 1484.3614 us/s
  localparam real         SLOPE_FULL_NS   = 1484361.4;
  localparam real         SLOPE_STEPS     = 16777216.0;
  localparam logic [2:0]  SLOPE_PROG      = 3'h7;
  localparam logic [23:0] SLOPE_61US  = 24'(int'(61000.0*SLOPE_STEPS/SLOPE_FULL_NS));
  localparam logic [23:0] SLOPE_885NS = 24'(int'(885.0*SLOPE_STEPS/SLOPE_FULL_NS));
  localparam logic [23:0] SLOPE_7U5   = 24'(int'(7500.0*SLOPE_STEPS/SLOPE_FULL_NS));
  localparam logic [23:0] SLOPE_1M4   = 24'(int'(1400000.0*SLOPE_STEPS/SLOPE_FULL_NS));
  localparam logic [23:0] SLOPE_1NS   = 24'(int'(1.0*SLOPE_STEPS/SLOPE_FULL_NS));
  localparam logic [23:0] SLOPE_5NS   = 24'(int'(5.0*SLOPE_STEPS/SLOPE_FULL_NS));
  localparam logic [23:0] SLOPE_10NS  = 24'(int'(10.0*SLOPE_STEPS/SLOPE_FULL_NS));
  // Clock figures
  localparam real         CLK_PERIOD_NS   = 8.0;
  localparam real         SECOND_NS       = 1.0e9;
  localparam int          TICKS_SEC_DFLT  = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam real         HIT_TRANSIENT_NS = 0.61;
endpackage

// File: tb/tb_dhs_ctrl.sv
// Self-checking bench for the holdover, hitless and slope control block
`timescale 1ns/100ps
module tb_dhs_ctrl
  import dhs_pkg::*;
;
  logic               core_clk;
  logic               rstn;
  logic               clk_en;
  logic [5:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic [2:0]         op_mode;
  logic [2:0]         sel_ref;
  logic signed [39:0] loop_freq;
  logic signed [31:0] phase_meas;
  logic               holdover_active;
  logic               phase_lock_en;
  logic signed [39:0] holdover_freq;
  logic signed [31:0] phase_comp;
  logic               hitless_event;
  logic [23:0]        slope_limit;
  logic               mode_change_irq;
  int                 n_errors;
  int                 n_checks;
  int                 n_hit;
  int                 n0;
  logic [31:0]        rd;
  logic [23:0]        slope_tab [7] = '{SLOPE_61US, SLOPE_885NS, SLOPE_7U5,
    SLOPE_1M4, SLOPE_1NS, SLOPE_5NS, SLOPE_10NS};

  // Short history step keeps the run brief
  dhs_ctrl #(.TICKS_PER_SEC(16)) i_dhs_ctrl (.*);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Counts registered pulses once each
  always @(posedge core_clk) begin
    if (hitless_event === 1'b1) begin
      n_hit++;
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge core_clk);
    // Seen in the edge's own step, before the slave updates
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_errors++;
        complete_run();
      end
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    op_mode = MODE_LOCKED;
    sel_ref = 3'h0;
    loop_freq = 40'sh0012345678;
    phase_meas = 32'sh00000040;
    n_errors = 0;
    n_checks = 0;
    n_hit = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk(OFS_METHOD, 32'(METHOD_RST));
    rd_chk(OFS_SWITCH, 32'(SWITCH_RST));
    rd_chk(OFS_SLOPE_SEL, 32'(SLOPE_SEL_RST));
    rd_chk(OFS_PROG_SLOPE, 32'h0);
    chk(slope_limit, 24'h0);
    rd_chk(6'h3C, 32'h0);
    // Leaving free-run after reset counts as a mode change
    rd_chk(OFS_STATUS, 32'h1);
    chk(mode_change_irq, 1'b0);
    bus(1'b1, OFS_MASK, 32'h1);
    chk(mode_change_irq, 1'b1);
    bus(1'b1, OFS_STATUS, 32'h1);
    chk(mode_change_irq, 1'b0);
    for (int c = 0; c < 7; c++) begin
      bus(1'b1, OFS_SLOPE_SEL, 32'(c));
      chk(slope_limit, slope_tab[c]);
    end
    bus(1'b1, OFS_PROG_SLOPE, 32'h00123456);
    bus(1'b1, OFS_SLOPE_SEL, 32'h7);
    chk(slope_limit, 24'h123456);
    // Reference change with hitless switching on
    bus(1'b1, OFS_SWITCH, 32'h1);
    n0 = n_hit;
    @(posedge core_clk);
    sel_ref <= 3'h2;
    repeat (4) @(negedge core_clk);
    chk(n_hit, n0 + 1);
    chk(phase_comp, 32'sh40);
    // Frozen: a further change must leave compensation alone
    bus(1'b1, OFS_SWITCH, 32'h3);
    n0 = n_hit;
    @(posedge core_clk);
    sel_ref <= 3'h3;
    phase_meas <= 32'sh00000200;
    repeat (4) @(negedge core_clk);
    chk(n_hit, n0);
    chk(phase_comp, 32'sh40);
    bus(1'b1, OFS_SWITCH, 32'h1);
    // Manual offset wins even with averaging enabled
    bus(1'b1, OFS_MAN_LO, 32'h89ABCDEF);
    bus(1'b1, OFS_MAN_HI, 32'h000000F6);
    rd_chk(OFS_MAN_HI, 32'h000000F6);
    bus(1'b1, OFS_METHOD, 32'h13);
    @(posedge core_clk);
    op_mode <= MODE_HOLDOVER;
    repeat (3) @(negedge core_clk);
    chk(holdover_active, 1'b1);
    chk(phase_lock_en, 1'b0);
    chk(holdover_freq, 40'shF689ABCDEF);
    bus(1'b1, OFS_MAN_LO, 32'h00000001);
    chk(holdover_freq, 40'shF689ABCDEF);
    bus(1'b1, OFS_METHOD, 32'h53);
    rd_chk(OFS_MAN_LO, 32'h89ABCDEF);
    // Leaving holdover is itself a hitless trigger
    n0 = n_hit;
    @(posedge core_clk);
    op_mode <= MODE_LOCKED;
    repeat (4) @(negedge core_clk);
    chk(n_hit, n0 + 1);
    chk(phase_lock_en, 1'b1);
    chk(holdover_active, 1'b0);
    // Hitless off: compensation slews back one unit per cycle
    bus(1'b1, OFS_SWITCH, 32'h0);
    repeat (16) @(negedge core_clk);
    chk(phase_comp, 32'sh1F0);
    // A zero programmable limit stops the slew
    bus(1'b1, OFS_PROG_SLOPE, 32'h0);
    repeat (16) @(negedge core_clk);
    chk(phase_comp, 32'sh1ED);
    rd_chk(OFS_PHASE, 32'h1ED);
    // No 64 s snapshot exists yet, while the current average is live
    bus(1'b1, OFS_METHOD, 32'h4E);
    rd_chk(OFS_MAN_LO, 32'h0);
    bus(1'b1, OFS_METHOD, 32'h70);
    bus(1'b0, OFS_MAN_LO, 32'h0);
    chk(rd != 32'h0 && rd < 32'h12345678, 1'b1);
    complete_run();
  end
endmodule
